//--- jlie_cond.sv
// jlie_cond.sv: condition code evaluation against the current flags
// assumes: flags come from the core's flag register on the same clock
`timescale 1ns/1ps
module jlie_cond
	import jlie_pkg::*;
(
	input  wire logic [3:0]  i_condition_code,
	input  wire jlie_flags_t i_flags,
	output logic             o_true
);
	// ---------------------------------------------------------------
	// standard table: low half false-ish forms, upper half inverses
	// ---------------------------------------------------------------
	logic base;

	// codes 8..f are the complements of 0..7
	always_comb begin
		base = 1'b0;
		unique case (i_condition_code[2:0])
			3'h0: base = 1'b0;                                      // never
			3'h1: base = i_flags.s ^ i_flags.v;                     // lt
			3'h2: base = i_flags.z | (i_flags.s ^ i_flags.v);       // le
			3'h3: base = i_flags.c | i_flags.z;                     // ule
			3'h4: base = i_flags.v;                                 // ov
			3'h5: base = i_flags.s;                                 // mi
			3'h6: base = i_flags.z;                                 // eq
			3'h7: base = i_flags.c;                                 // ult
		endcase
		o_true = i_condition_code[3] ? ~base : base;
	end
endmodule

//--- jlie_exec.sv
// jlie_exec.sv: decode and execute jumps, register loads, bit loads, memory loads
// assumes: the fetch unit presents whole instructions (up to three bytes) with a
// start strobe; register file reads are combinational; memory acks inside the instruction's cycle slot
`timescale 1ns/1ps
`include "jlie_map.svh"
module jlie_exec
	import jlie_pkg::*;
(
	input  wire logic          i_mclk,
	input  wire logic          i_reset_n,
	input  wire logic          i_start,
	input  wire logic [7:0]    i_byte0,
	input  wire logic [7:0]    i_byte1,
	input  wire logic [7:0]    i_byte2,
	input  wire logic [15:0]   i_pc,
	input  wire jlie_flags_t   i_flags,
	input  wire logic [7:0]    i_working_base,
	output logic [7:0]         o_rd_addr_a,
	input  wire logic [7:0]    i_rd_data_a,
	output logic [7:0]         o_rd_addr_b,
	input  wire logic [7:0]    i_rd_data_b,
	output jlie_reg_wr_t       o_reg_wr,
	output jlie_mem_req_t      o_mem,
	input  wire logic          i_mem_ack,
	input  wire logic [7:0]    i_mem_rdata,
	output logic               o_pc_load,
	output logic [15:0]        o_pc_value,
	output jlie_flags_t        o_flags,
	output logic               o_busy,
	output logic               o_done,
	output logic               o_illegal
);
	// ---------------------------------------------------------------
	// decode of the presented instruction
	// ---------------------------------------------------------------
	logic        is_jp_cc;
	logic        is_jr;
	logic        is_jp_ind;
	logic        is_ldb;
	logic        is_ld_rr;
	logic        is_ldm_ld;
	logic        is_ldm_st;
	logic        cond_true;
	logic [7:0]  wr_addr;
	logic [7:0]  pair_hi_addr;
	logic [7:0]  pair_lo_addr;
	logic [2:0]  bit_idx;
	logic [15:0] next_seq_pc;
	logic [1:0]  ins_len;
	logic [3:0]  ins_cyc;
	// sequencer state, declared here because the read ports look at it
	jlie_state_t   state_reg, state_next;
	logic [3:0]    cnt_reg, cnt_next;
	logic          pc_ld_reg, pc_ld_next;
	logic [15:0]   pc_val_reg, pc_val_next;
	jlie_reg_wr_t  wr_reg, wr_next;
	jlie_mem_req_t mem_reg, mem_next;
	logic          mem_is_load_reg, mem_is_load_next;
	logic          mem_pend_reg, mem_pend_next;
	logic [7:0]    mem_dst_reg, mem_dst_next;

	assign is_jp_cc  = (i_byte0[3:0] == `JLIE_NIB_JP_CC);
	assign is_jr     = (i_byte0[3:0] == `JLIE_NIB_JR_CC);
	assign is_jp_ind = (i_byte0 == `JLIE_OP_JP_IND);
	assign is_ldb    = (i_byte0 == `JLIE_OP_LDB);
	assign is_ld_rr  = (i_byte0 == `JLIE_OP_LD_R_R);
	assign is_ldm_ld = (i_byte0 == `JLIE_OP_LDM_LOAD);
	assign is_ldm_st = (i_byte0 == `JLIE_OP_LDM_STORE);

	jlie_cond u_cond (
		.i_condition_code (i_byte0[7:4]),
		.i_flags          (i_flags),
		.o_true           (cond_true)
	);

	// working register nibble plus the pointer base, pair forced even
	assign wr_addr      = i_working_base | {4'h0, i_byte1[7:4]};
	assign pair_hi_addr = i_working_base | {4'h0, i_byte1[3:1], 1'b0};
	assign pair_lo_addr = i_working_base | {4'h0, i_byte1[3:1], 1'b1};
	assign bit_idx      = i_byte1[`JLIE_LDB_IDX_LSB +: 3];

	// length and timing per instruction class
	always_comb begin
		ins_len = `JLIE_LEN_JR;
		ins_cyc = `JLIE_CYC_ONE;
		o_illegal = 1'b0;
		if (is_jp_cc) begin
			ins_len = `JLIE_LEN_JP_CC;
			ins_cyc = `JLIE_CYC_JP;
		end else if (is_jr) begin
			ins_len = `JLIE_LEN_JR;
			ins_cyc = `JLIE_CYC_JR;
		end else if (is_jp_ind) begin
			ins_len = `JLIE_LEN_JP_IND;
			ins_cyc = `JLIE_CYC_JP;
		end else if (is_ldb) begin
			ins_len = `JLIE_LEN_LDB;
			ins_cyc = `JLIE_CYC_LDB;
		end else if (is_ld_rr) begin
			ins_len = `JLIE_LEN_LD_R_R;
			ins_cyc = `JLIE_CYC_LD_R_R;
		end else if (is_ldm_ld || is_ldm_st) begin
			ins_len = `JLIE_LEN_LDM;
			ins_cyc = `JLIE_CYC_LDM;
		end else begin
			o_illegal = i_start;
		end
	end

	// pc after the whole instruction, also the relative base
	assign next_seq_pc = i_pc + {14'h0000, ins_len};

	// ---------------------------------------------------------------
	// register file read ports
	// ---------------------------------------------------------------
	// port a: pair high, bit-load working reg, copy source, or store data while in JLIE_MEM
	always_comb begin
		o_rd_addr_a = pair_hi_addr;
		o_rd_addr_b = pair_lo_addr;
		if (is_jp_ind) begin
			o_rd_addr_a = i_byte1;
			o_rd_addr_b = {i_byte1[7:1], 1'b1};
		end else if (is_ldb) begin
			o_rd_addr_a = wr_addr;
			o_rd_addr_b = i_byte2;
		end else if (is_ld_rr) begin
			o_rd_addr_a = i_byte1;
			o_rd_addr_b = i_byte2;
		end
		// a store reads its data byte one cycle late: both ports serve the pointer first
		if (state_reg == JLIE_MEM) begin
			o_rd_addr_a = mem_dst_reg;
		end
	end

	// ---------------------------------------------------------------
	// sequencer: capture results at start (memory loads write at ack), hold busy for the cycle count
	// ---------------------------------------------------------------
	logic [7:0]    merged;

	// single-bit merge for the store-into-general form
	always_comb begin
		merged = i_rd_data_b;
		merged[bit_idx] = i_rd_data_a[0];
	end

	always_comb begin
		state_next       = state_reg;
		cnt_next         = cnt_reg;
		pc_ld_next       = 1'b0;
		pc_val_next      = pc_val_reg;
		wr_next          = '0;
		mem_next         = mem_reg;
		mem_is_load_next = mem_is_load_reg;
		mem_pend_next    = mem_pend_reg;
		mem_dst_next     = mem_dst_reg;
		unique case (state_reg)
			JLIE_IDLE: begin
				if (i_start && !o_illegal) begin
					cnt_next    = ins_cyc - `JLIE_CYC_ONE;
					pc_ld_next  = 1'b1;
					pc_val_next = next_seq_pc;
					state_next  = JLIE_WAIT;
					if (is_jp_cc && cond_true) begin
						pc_val_next = {i_byte1, i_byte2};
					end else if (is_jr && cond_true) begin
						pc_val_next = next_seq_pc + {{8{i_byte1[7]}}, i_byte1};
					end else if (is_jp_ind) begin
						pc_val_next = {i_rd_data_a, i_rd_data_b};
					end else if (is_ldb && !i_byte1[`JLIE_LDB_DIR_BIT]) begin
						wr_next.we   = 1'b1;
						wr_next.addr = wr_addr;
						wr_next.data = {i_rd_data_a[7:1], i_rd_data_b[bit_idx]};
					end else if (is_ldb) begin
						wr_next.we   = 1'b1;
						wr_next.addr = i_byte2;
						wr_next.data = merged;
					end else if (is_ld_rr) begin
						wr_next.we   = 1'b1;
						wr_next.addr = i_byte2;
						wr_next.data = i_rd_data_a;
					end else if (is_ldm_ld || is_ldm_st) begin
						mem_next.req        = is_ldm_ld;
						mem_next.write      = is_ldm_st;
						mem_next.data_space = i_byte1[`JLIE_PAIR_SPACE_BIT];
						mem_next.addr       = {i_rd_data_a, i_rd_data_b};
						mem_next.wdata      = `JLIE_ZERO_BYTE;
						mem_pend_next       = is_ldm_st;
						mem_is_load_next    = is_ldm_ld;
						mem_dst_next        = wr_addr;
						state_next          = JLIE_MEM;
					end
				end
			end
			JLIE_MEM: begin
				// transfer must end inside the slot so the next fetch is clean
				if (cnt_reg != 4'h0) begin
					cnt_next = cnt_reg - `JLIE_CYC_ONE;
				end
				if (mem_pend_reg) begin
					mem_next.req   = 1'b1;
					mem_next.wdata = i_rd_data_a;
					mem_pend_next  = 1'b0;
				end else if (i_mem_ack && mem_reg.req) begin
					mem_next.req = 1'b0;
					if (mem_is_load_reg) begin
						wr_next.we   = 1'b1;
						wr_next.addr = mem_dst_reg;
						wr_next.data = i_mem_rdata;
					end
					state_next = JLIE_WAIT;
				end
			end
			JLIE_WAIT: begin
				if (cnt_reg <= `JLIE_CYC_ONE) begin
					state_next = JLIE_DONE;
				end else begin
					cnt_next = cnt_reg - `JLIE_CYC_ONE;
				end
			end
			JLIE_DONE: begin
				state_next = JLIE_IDLE;
			end
			default: begin
				state_next = JLIE_IDLE;
			end
		endcase
	end

	// registers only; synchronous active-low reset
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			state_reg       <= JLIE_IDLE;
			cnt_reg         <= 4'h0;
			pc_ld_reg       <= 1'b0;
			pc_val_reg      <= `JLIE_RESET_PC;
			wr_reg          <= '0;
			mem_reg         <= '0;
			mem_is_load_reg <= 1'b0;
			mem_pend_reg    <= 1'b0;
			mem_dst_reg     <= `JLIE_ZERO_BYTE;
		end else begin
			state_reg       <= state_next;
			cnt_reg         <= cnt_next;
			pc_ld_reg       <= pc_ld_next;
			pc_val_reg      <= pc_val_next;
			wr_reg          <= wr_next;
			mem_reg         <= mem_next;
			mem_is_load_reg <= mem_is_load_next;
			mem_pend_reg    <= mem_pend_next;
			mem_dst_reg     <= mem_dst_next;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign o_pc_load  = pc_ld_reg;
	assign o_pc_value = pc_val_reg;
	assign o_reg_wr   = wr_reg;
	assign o_mem      = mem_reg;
	assign o_flags    = i_flags;                // flags pass untouched
	assign o_busy     = (state_reg != JLIE_IDLE);
	assign o_done     = (state_reg == JLIE_DONE);
endmodule

//--- jlie_exec_assertions.sv
// jlie_exec_assertions.sv: timing and value checks on the jump/load executor
// assumes: bound onto jlie_exec; single clock i_mclk, sync active-low reset
`timescale 1ns/1ps
module jlie_exec_checker
	import jlie_pkg::*;
(
	input wire logic          i_mclk,
	input wire logic          i_reset_n,
	input wire logic          i_start,
	input wire logic [7:0]    i_byte0,
	input wire logic [7:0]    i_byte1,
	input wire logic [7:0]    i_byte2,
	input wire logic [15:0]   i_pc,
	input wire jlie_flags_t   i_flags,
	input wire logic          i_mem_ack,
	input wire jlie_mem_req_t o_mem,
	input wire logic          o_pc_load,
	input wire logic [15:0]   o_pc_value,
	input wire jlie_flags_t   o_flags,
	input wire logic          o_busy,
	input wire logic          o_done
);
	// ---------------------------------------------------------------
	// helpers and properties
	// ---------------------------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	logic        take;
	logic [15:0] rel_target;
	logic        space_sel;
	// accepted start; relative target precomputed so $past sees one signal
	assign take       = i_start && !o_busy;
	assign rel_target = i_pc + 16'h0002 + {{8{i_byte1[7]}}, i_byte1};
	assign space_sel  = i_byte1[0];

	property p_jp_time;
		take && i_byte0[3:0] == 4'hd |-> ##1 o_busy [*7] ##1 o_done;
	endproperty
	a_jp_time: assert property (p_jp_time) else $error("conditional jump not done in 8 cycles");
	property p_jp_target;
		take && i_byte0 == 8'h8d |-> ##1 o_pc_load && o_pc_value == {$past(i_byte1), $past(i_byte2)};
	endproperty
	a_jp_target: assert property (p_jp_target) else $error("jump target wrong");
	property p_jp_false;
		take && i_byte0 == 8'h0d |-> ##1 o_pc_load && o_pc_value == $past(i_pc) + 16'h0003;
	endproperty
	a_jp_false: assert property (p_jp_false) else $error("false jump moved pc");
	property p_ind_time;
		take && i_byte0 == 8'h30 |-> ##8 o_done;
	endproperty
	a_ind_time: assert property (p_ind_time) else $error("indirect jump not done in 8 cycles");
	property p_jr_time;
		take && i_byte0[3:0] == 4'hb |-> ##1 o_busy [*5] ##1 o_done;
	endproperty
	a_jr_time: assert property (p_jr_time) else $error("relative jump not done in 6 cycles");
	property p_jr_target;
		take && i_byte0 == 8'h8b |-> ##1 o_pc_load && o_pc_value == $past(rel_target);
	endproperty
	a_jr_target: assert property (p_jr_target) else $error("relative target wrong");
	property p_ldb_time;
		take && i_byte0 == 8'h47 |-> ##6 o_done;
	endproperty
	a_ldb_time: assert property (p_ldb_time) else $error("bit load not done in 6 cycles");
	property p_flags;
		o_flags == i_flags;
	endproperty
	a_flags: assert property (p_flags) else $error("flags altered");
	property p_mem_space;
		take && i_byte0 == 8'hc3 |-> ##1 o_mem.req && !o_mem.write && o_mem.data_space == $past(space_sel);
	endproperty
	a_mem_space: assert property (p_mem_space) else $error("memory space or direction wrong");
	property p_mem_release;
		o_mem.req && i_mem_ack |=> !o_mem.req;
	endproperty
	a_mem_release: assert property (p_mem_release) else $error("memory request held after ack");
	c_jp_taken: cover property (take && i_byte0 == 8'h8d);
	c_ldb: cover property (take && i_byte0 == 8'h47);
	c_mem_slow: cover property ((o_mem.req && !i_mem_ack) [*5]);
	c_mem_store: cover property (take && i_byte0 == 8'hd3);
endmodule

bind jlie_exec jlie_exec_checker i_jlie_exec_checker (.i_mclk, .i_reset_n, .i_start, .i_byte0,
	.i_byte1, .i_byte2, .i_pc, .i_flags, .i_mem_ack, .o_mem, .o_pc_load, .o_pc_value, .o_flags,
	.o_busy, .o_done);

//--- jlie_map.svh
// jlie_map.svh: opcode, field and timing constants for the jump/load executor
// assumes: included by bare name from the package and the executor files
`ifndef JLIE_MAP_SVH
`define JLIE_MAP_SVH

// ---------------------------------------------------------------
// opcodes and nibbles
// ---------------------------------------------------------------
`define JLIE_NIB_JP_CC      4'hd
`define JLIE_NIB_JR_CC      4'hb
`define JLIE_OP_JP_IND      8'h30
`define JLIE_OP_LDB         8'h47
`define JLIE_OP_LD_R_R      8'he4
`define JLIE_OP_LDM_LOAD    8'hc3
`define JLIE_OP_LDM_STORE   8'hd3

// ---------------------------------------------------------------
// instruction lengths and cycle counts
// ---------------------------------------------------------------
`define JLIE_LEN_JP_CC      2'd3
`define JLIE_LEN_JP_IND     2'd2
`define JLIE_LEN_JR         2'd2
`define JLIE_LEN_LDB        2'd3
`define JLIE_LEN_LD_R_R     2'd3
`define JLIE_LEN_LDM        2'd2
`define JLIE_CYC_JP         4'd8
`define JLIE_CYC_JR         4'd6
`define JLIE_CYC_LDB        4'd6
`define JLIE_CYC_LD_R_R     4'd6
`define JLIE_CYC_LDM        4'd10
`define JLIE_CYC_ONE        4'd1

// ---------------------------------------------------------------
// field positions, reset pc and zero byte
// ---------------------------------------------------------------
`define JLIE_LDB_DIR_BIT    0
`define JLIE_LDB_IDX_LSB    1
`define JLIE_LDB_WR_LSB     4
`define JLIE_PAIR_SPACE_BIT 0
`define JLIE_RESET_PC       16'h0000
`define JLIE_ZERO_BYTE      8'h00

`endif

//--- jlie_mem_model.sv
// jlie_mem_model.sv: program and data memory behind the executor's memory port
// assumes: request level held until the cycle after ack; one-cycle ack
`timescale 1ns/1ps
module jlie_mem_model
	import jlie_pkg::*;
(
	input  wire logic          i_mclk,
	input  wire jlie_mem_req_t i_mem,
	input  wire logic [2:0]    i_delay,
	output logic               o_ack,
	output logic [7:0]         o_rdata
);
	// ---------------------------------------------------------------
	// storage and answer
	// ---------------------------------------------------------------
	logic [7:0] prog [0:65535];
	logic [7:0] data [0:65535];
	logic       served = 1'b0;
	logic [2:0] wait_cnt = 3'd0;
	initial o_ack = 1'b0;
	initial o_rdata = 8'h00;
	// served blocks a second ack while the request is still dropping
	always @(posedge i_mclk) begin
		o_ack <= 1'b0;
		o_rdata <= ~o_rdata; // released bus: never repeats a stale byte
		if (!i_mem.req) begin
			served <= 1'b0;
			wait_cnt <= 3'd0;
		end else if (!served && wait_cnt != i_delay) begin
			wait_cnt <= wait_cnt + 3'd1; // slow answer when delay set
		end else if (!served) begin
			o_ack <= 1'b1;
			served <= 1'b1;
			if (i_mem.write && i_mem.data_space) data[i_mem.addr] <= i_mem.wdata;
			if (i_mem.write && !i_mem.data_space) prog[i_mem.addr] <= i_mem.wdata;
			if (!i_mem.write) o_rdata <= i_mem.data_space ? data[i_mem.addr] : prog[i_mem.addr];
		end
	end
endmodule

//--- jlie_pkg.sv
// jlie_pkg.sv: types shared by the jump/load executor and its condition unit
// assumes: jlie_map.svh is on the include path
package jlie_pkg;
	`include "jlie_map.svh"

	// flag byte as the core holds it, upper bits first
	typedef struct packed {
		logic c;
		logic z;
		logic s;
		logic v;
		logic d;
		logic h;
		logic fis;
		logic bank;
	} jlie_flags_t;

	// one register file write request
	typedef struct packed {
		logic       we;
		logic [7:0] addr;
		logic [7:0] data;
	} jlie_reg_wr_t;

	// memory transfer request toward program or data memory
	typedef struct packed {
		logic        req;
		logic        write;
		logic        data_space;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} jlie_mem_req_t;

	typedef enum logic [2:0] {
		JLIE_IDLE,
		JLIE_WAIT,
		JLIE_MEM,
		JLIE_DONE
	} jlie_state_t;
endpackage

//--- testbench.sv
// testbench.sv: directed scenarios for the jump/load executor
// assumes: register file modelled here as a 256-byte array with comb reads
`timescale 1ns/1ps
module testbench;
	import jlie_pkg::*;
	// ---------------------------------------------------------------
	// stimulus, register file and instances
	// ---------------------------------------------------------------
	logic          i_mclk = 1'b0;
	logic          i_reset_n = 1'b0;
	logic          i_start = 1'b0;
	logic [7:0]    i_byte0 = 8'h00;
	logic [7:0]    i_byte1 = 8'h00;
	logic [7:0]    i_byte2 = 8'h00;
	logic [15:0]   i_pc = 16'h0000;
	jlie_flags_t   i_flags = 8'h00;
	logic [7:0]    i_working_base = 8'hc0;
	logic [2:0]    mem_delay = 3'd0;
	logic [7:0]    regs [0:255];
	logic [7:0]    o_rd_addr_a, o_rd_addr_b, i_mem_rdata;
	logic [15:0]   o_pc_value;
	logic          i_mem_ack, o_pc_load, o_busy, o_done, o_illegal;
	jlie_flags_t   o_flags;
	jlie_reg_wr_t  o_reg_wr;
	jlie_mem_req_t o_mem;
	int            n_errors = 0;
	int            n_tests = 0;
	always #50 i_mclk = ~i_mclk;
	always @(posedge i_mclk) if (o_reg_wr.we === 1'b1) regs[o_reg_wr.addr] <= o_reg_wr.data;

	jlie_exec i_jlie_exec (.i_mclk, .i_reset_n, .i_start, .i_byte0, .i_byte1, .i_byte2, .i_pc,
		.i_flags, .i_working_base, .o_rd_addr_a, .i_rd_data_a(regs[o_rd_addr_a]), .o_rd_addr_b,
		.i_rd_data_b(regs[o_rd_addr_b]), .o_reg_wr, .o_mem, .i_mem_ack, .i_mem_rdata, .o_pc_load,
		.o_pc_value, .o_flags, .o_busy, .o_done, .o_illegal);
	jlie_mem_model i_jlie_mem_model (.i_mclk, .i_mem(o_mem), .i_delay(mem_delay),
		.o_ack(i_mem_ack), .o_rdata(i_mem_rdata));

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	// one instruction: cyc counts from the taking edge, npc is the pc that follows
	task automatic run(input logic [7:0] b0, b1, b2, input logic [15:0] pc, input int len,
		output int cyc, output logic [15:0] npc);
		@(posedge i_mclk);
		i_start <= 1'b1;
		i_byte0 <= b0;
		i_byte1 <= b1;
		i_byte2 <= b2;
		i_pc <= pc;
		@(posedge i_mclk);
		i_start <= 1'b0;
		npc = pc + 16'(len);
		cyc = 1;
		#1;
		while (o_done !== 1'b1 && cyc < 40) begin
			if (o_pc_load === 1'b1) npc = o_pc_value;
			@(posedge i_mclk);
			#1;
			cyc++;
		end
	endtask
	task automatic tally_and_finish;
		$display("tests %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_jump_abs;
		int cyc;
		logic [15:0] npc;
		run(8'h8d, 8'h12, 8'h34, 16'h0100, 3, cyc, npc);
		check(npc, 16'h1234, "taken absolute target");
		check(16'(cyc), 16'd8, "absolute jump cycles");
		run(8'h0d, 8'h12, 8'h34, 16'h0100, 3, cyc, npc);
		check(npc, 16'h0103, "untaken jump falls through");
		regs[8'h20] = 8'h01;
		regs[8'h21] = 8'h20;
		run(8'h30, 8'h20, 8'h00, 16'h0200, 2, cyc, npc);
		check(npc, 16'h0120, "indirect target high byte first");
		check(16'(cyc), 16'd8, "indirect jump cycles");
		$display("test jump_absolute done");
	endtask
	task automatic t_jump_rel;
		int cyc;
		logic [15:0] npc;
		logic [7:0] d [3] = '{8'h7f, 8'h80, 8'hfe};
		i_flags <= 8'hff; // every flag set: none may be cleared
		foreach (d[k]) begin
			run(8'h8b, d[k], 8'h00, 16'h1000, 2, cyc, npc);
			check(npc, 16'h1002 + {{8{d[k][7]}}, d[k]}, "relative target");
			check(16'(cyc), 16'd6, "relative jump cycles");
		end
		run(8'h0b, 8'h40, 8'h00, 16'h1000, 2, cyc, npc);
		check(npc, 16'h1002, "untaken relative falls through");
		check({8'h00, o_flags}, {8'h00, i_flags}, "flags kept");
		$display("test jump_relative done");
	endtask
	task automatic t_loads;
		int cyc;
		logic [15:0] npc;
		regs[8'h30] = 8'h5a;
		regs[8'h31] = 8'h00;
		run(8'he4, 8'h30, 8'h31, 16'h0300, 3, cyc, npc);
		check({regs[8'h31], regs[8'h30]}, 16'h5a5a, "register copy, source kept");
		regs[8'hc2] = 8'h06;
		regs[8'h40] = 8'h05;
		run(8'h47, 8'h24, 8'h40, 16'h0400, 3, cyc, npc);
		check({regs[8'hc2], regs[8'h40]}, 16'h0705, "bit into working bit zero");
		check(16'(cyc), 16'd6, "bit load cycles");
		regs[8'hc2] = 8'h06;
		run(8'h47, 8'h21, 8'h40, 16'h0400, 3, cyc, npc);
		check({regs[8'hc2], regs[8'h40]}, 16'h0604, "bit zero into chosen bit");
		$display("test load_register done");
	endtask
	task automatic t_mem(input logic [2:0] delay);
		int cyc;
		logic [15:0] npc;
		mem_delay = delay;
		{regs[8'hc4], regs[8'hc5]} = 16'h0104;
		i_jlie_mem_model.prog[16'h0104] = 8'h1a;
		i_jlie_mem_model.data[16'h0104] = 8'h2a;
		run(8'hc3, 8'h04, 8'h00, 16'h0500, 2, cyc, npc);
		check({8'h00, regs[8'hc0]}, 16'h001a, "even pair reads program memory");
		check(16'(cyc), 16'd10, "memory load cycles");
		run(8'hc3, 8'h05, 8'h00, 16'h0502, 2, cyc, npc);
		check({8'h00, regs[8'hc0]}, 16'h002a, "odd pair reads data memory");
		regs[8'hc0] = 8'h11;
		run(8'hd3, 8'h04, 8'h00, 16'h0504, 2, cyc, npc);
		check({i_jlie_mem_model.prog[16'h0104], regs[8'hc0]}, 16'h1111, "store to program");
		check(16'(cyc), 16'd10, "memory store cycles");
		run(8'hd3, 8'h05, 8'h00, 16'h0506, 2, cyc, npc);
		check({8'h00, i_jlie_mem_model.data[16'h0104]}, 16'h0011, "odd pair stores to data");
		$display("test memory_load delay %0d done", delay);
	endtask
	task automatic t_refuse;
		@(posedge i_mclk);
		i_start <= 1'b1;
		i_byte0 <= 8'hff;
		#1;
		check({15'h0000, o_illegal}, 16'h0001, "unknown opcode flagged");
		@(posedge i_mclk);
		i_start <= 1'b0;
		#1;
		check({15'h0000, o_busy}, 16'h0000, "unknown opcode not started");
		$display("test refuse done");
	endtask

	// ---------------------------------------------------------------
	// sequence and watchdog
	// ---------------------------------------------------------------
	initial begin
		repeat (12) @(posedge i_mclk);
		i_reset_n <= 1'b1;
		t_jump_abs();
		t_jump_rel();
		t_loads();
		t_mem(3'd0);
		t_mem(3'd5);
		t_refuse();
		tally_and_finish();
	end
	// about 200 cycles of work expected; fifteen times that means a hang
	initial begin
		repeat (3000) @(posedge i_mclk);
		n_errors++;
		$display("mismatch at %0t: watchdog expired", $time);
		tally_and_finish();
	end
endmodule
